// ### rtl/holding_read_pkg.sv
// constants, image layout and crc helper for the holding register read responder
package holding_read_pkg;
    // ----------------------------------------------------------------
    // frame fields
    // ----------------------------------------------------------------
    localparam logic [7:0] SLAVE_ADDR_MIN = 8'h01;
    localparam logic [7:0] SLAVE_ADDR_MAX = 8'hf7;
    localparam logic [7:0] FUNC_READ_HOLD = 8'h03;
    localparam logic [2:0] REQ_LAST_IDX = 3'h7;
    localparam logic [2:0] REQ_IDX_ADDR = 3'h0;
    localparam logic [2:0] REQ_IDX_FUNC = 3'h1;
    localparam logic [2:0] REQ_IDX_START_HI = 3'h2;
    localparam logic [2:0] REQ_IDX_START_LO = 3'h3;
    localparam logic [2:0] REQ_IDX_CNT_HI = 3'h4;
    localparam logic [2:0] REQ_IDX_CNT_LO = 3'h5;
    localparam logic [7:0] RSP_HDR_LEN = 8'h03;
    localparam logic [7:0] RSP_IDX_FUNC = 8'h01;
    localparam logic [7:0] RSP_IDX_COUNT = 8'h02;
    // ----------------------------------------------------------------
    // crc
    // ----------------------------------------------------------------
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_GOOD_RESIDUE = 16'h0000;
    // ----------------------------------------------------------------
    // holding register image, word indices
    // ----------------------------------------------------------------
    localparam int IMAGE_WORDS = 35;
    localparam int IMAGE_AW = 6;
    localparam logic [16:0] IMAGE_WORDS_17 = 17'h00023;
    localparam logic [5:0] IDX_ANALOG_OUTPUT_ONE = 6'h00;
    localparam logic [5:0] IDX_ANALOG_OUTPUT_TWO = 6'h01;
    localparam logic [5:0] IDX_DIGITAL_INPUT_ONE_SETTING = 6'h02;
    localparam logic [5:0] IDX_DIGITAL_INPUT_ONE_COUNT = 6'h03;
    localparam logic [5:0] IDX_DIGITAL_OUTPUT_ONE_COUNT = 6'h05;
    localparam logic [5:0] IDX_DIGITAL_OUTPUT_ONE_FREQ = 6'h07;
    localparam logic [5:0] IDX_DIGITAL_OUTPUT_ONE_DUTY = 6'h08;
    localparam logic [5:0] IDX_DIGITAL_OUTPUT_TWO_DIR = 6'h09;
    localparam logic [5:0] IDX_DIGITAL_OUTPUT_ONE_NUMBER = 6'h0a;
    localparam logic [5:0] IDX_DIGITAL_OUTPUT_ONE_CTRL = 6'h0c;
    localparam logic [5:0] IDX_INPUT_COUNTS_BASE = 6'h0d;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_SEND = 4'b1000
    } resp_state_t;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] x;
        x = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction
endpackage

// ### rtl/holding_image_mem.sv
// register image memory: one write port, one read port with registered data
`timescale 1ns/1ps
module holding_image_mem (
    input wire logic clk_sys_i,
    input wire logic wr_en_i,
    input wire logic [5:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [5:0] rd_addr_i,
    output logic [15:0] rd_data_o
);
    logic [15:0] mem_r [holding_read_pkg::IMAGE_WORDS];

    // ----------------------------------------------------------------
    // write and read ports
    // ----------------------------------------------------------------
    // out of range writes are dropped so the image never aliases
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i && (int'(wr_addr_i) < holding_read_pkg::IMAGE_WORDS)) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rd_en_i) begin
            rd_data_o <= mem_r[rd_addr_i];
        end
    end
endmodule

// ### rtl/holding_register_read_responder.sv
// read holding registers request decoder and reply generator
`timescale 1ns/1ps
// Behaviour
// - act only on own address, 1 to 247
// - function byte 03h selects holding read
// - frames end in crc, low byte first
// - reply echoes address then function 03h
// - byte count equals twice register count
// - register data follow in address order
// - fixed 35 word image layout
module holding_register_read_responder (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] dev_addr_i,
    input wire logic rx_gap_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic img_wr_en_i,
    input wire logic [5:0] img_wr_addr_i,
    input wire logic [15:0] img_wr_data_i
);
    holding_read_pkg::resp_state_t state_r;
    logic [2:0] rx_idx_r;
    logic [15:0] rx_crc_r;
    logic [7:0] req_addr_r;
    logic [7:0] req_func_r;
    logic [15:0] req_start_r;
    logic [15:0] req_cnt_r;
    logic [15:0] rx_crc_nxt;
    logic [16:0] req_end;
    logic rx_last;
    logic accept;
    logic [7:0] tx_idx_r;
    logic [15:0] tx_crc_r;
    logic [15:0] word_r;
    logic [15:0] rd_data;
    logic [7:0] data_end;
    logic [7:0] data_off;
    logic [7:0] tx_idx_nxt;
    logic tx_fire;
    logic need_fetch;
    logic [5:0] rd_addr;

    // ----------------------------------------------------------------
    // request reception
    // ----------------------------------------------------------------
    assign rx_crc_nxt = holding_read_pkg::crc_step(rx_crc_r, rx_data_i);
    assign rx_last = (state_r == holding_read_pkg::ST_IDLE) && rx_valid_i
        && (rx_idx_r == holding_read_pkg::REQ_LAST_IDX);
    assign req_end = {1'b0, req_start_r} + {1'b0, req_cnt_r};
    // out of range or empty reads get no reply; no exception path here
    assign accept = rx_last
        && (rx_crc_nxt == holding_read_pkg::CRC_GOOD_RESIDUE)
        && (req_addr_r == dev_addr_i)
        && (req_addr_r >= holding_read_pkg::SLAVE_ADDR_MIN)
        && (req_addr_r <= holding_read_pkg::SLAVE_ADDR_MAX)
        && (req_func_r == holding_read_pkg::FUNC_READ_HOLD)
        && (req_cnt_r != 16'h0000)
        && (req_end <= holding_read_pkg::IMAGE_WORDS_17);

    // bytes seen while replying are ignored: the link is half duplex
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || rx_gap_i) begin
            rx_idx_r <= 3'h0;
            rx_crc_r <= holding_read_pkg::CRC_INIT;
        end else if ((state_r == holding_read_pkg::ST_IDLE) && rx_valid_i) begin
            rx_idx_r <= rx_idx_r + 3'h1;
            rx_crc_r <= rx_last ? holding_read_pkg::CRC_INIT : rx_crc_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            req_addr_r <= 8'h00;
            req_func_r <= 8'h00;
            req_start_r <= 16'h0000;
            req_cnt_r <= 16'h0000;
        end else if ((state_r == holding_read_pkg::ST_IDLE) && rx_valid_i) begin
            case (rx_idx_r)
                holding_read_pkg::REQ_IDX_ADDR: req_addr_r <= rx_data_i;
                holding_read_pkg::REQ_IDX_FUNC: req_func_r <= rx_data_i;
                holding_read_pkg::REQ_IDX_START_HI: req_start_r[15:8] <= rx_data_i;
                holding_read_pkg::REQ_IDX_START_LO: req_start_r[7:0] <= rx_data_i;
                holding_read_pkg::REQ_IDX_CNT_HI: req_cnt_r[15:8] <= rx_data_i;
                holding_read_pkg::REQ_IDX_CNT_LO: req_cnt_r[7:0] <= rx_data_i;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // reply sequencing
    // ----------------------------------------------------------------
    // count is at most 35 here, so 2n+5 fits one byte
    assign data_end = holding_read_pkg::RSP_HDR_LEN + {req_cnt_r[6:0], 1'b0};
    assign data_off = tx_idx_r - holding_read_pkg::RSP_HDR_LEN;
    assign tx_fire = tx_valid_o && tx_ready_i;
    assign tx_idx_nxt = tx_idx_r + 8'h01;
    assign need_fetch = (tx_idx_nxt >= holding_read_pkg::RSP_HDR_LEN)
        && (tx_idx_nxt < data_end)
        && ((tx_idx_nxt[0] ^ holding_read_pkg::RSP_HDR_LEN[0]) == 1'b0);
    // word index of the byte about to be sent: start plus offset over two
    assign rd_addr = req_start_r[5:0] + data_off[6:1];

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_r <= holding_read_pkg::ST_IDLE;
        end else begin
            case (state_r)
                holding_read_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_r <= holding_read_pkg::ST_SEND;
                    end
                end
                holding_read_pkg::ST_FETCH: state_r <= holding_read_pkg::ST_LOAD;
                holding_read_pkg::ST_LOAD: state_r <= holding_read_pkg::ST_SEND;
                holding_read_pkg::ST_SEND: begin
                    if (tx_fire) begin
                        if (tx_idx_r == data_end + 8'h01) begin
                            state_r <= holding_read_pkg::ST_IDLE;
                        end else if (need_fetch) begin
                            state_r <= holding_read_pkg::ST_FETCH;
                        end
                    end
                end
                default: state_r <= holding_read_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || (state_r == holding_read_pkg::ST_IDLE)) begin
            tx_idx_r <= 8'h00;
            tx_crc_r <= holding_read_pkg::CRC_INIT;
        end else if (tx_fire) begin
            tx_idx_r <= tx_idx_nxt;
            if (tx_idx_r < data_end) begin
                tx_crc_r <= holding_read_pkg::crc_step(tx_crc_r, tx_data_o);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            word_r <= 16'h0000;
        end else if (state_r == holding_read_pkg::ST_LOAD) begin
            word_r <= rd_data;
        end
    end

    holding_image_mem i_holding_image_mem (
        .clk_sys_i(clk_sys_i),
        .wr_en_i(img_wr_en_i),
        .wr_addr_i(img_wr_addr_i),
        .wr_data_i(img_wr_data_i),
        .rd_en_i(state_r == holding_read_pkg::ST_FETCH),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_data)
    );

    // ----------------------------------------------------------------
    // reply byte select
    // ----------------------------------------------------------------
    assign tx_valid_o = (state_r == holding_read_pkg::ST_SEND);

    always_comb begin
        if (tx_idx_r == 8'h00) begin
            tx_data_o = req_addr_r;
        end else if (tx_idx_r == holding_read_pkg::RSP_IDX_FUNC) begin
            tx_data_o = holding_read_pkg::FUNC_READ_HOLD;
        end else if (tx_idx_r == holding_read_pkg::RSP_IDX_COUNT) begin
            tx_data_o = {req_cnt_r[6:0], 1'b0};
        end else if (tx_idx_r < data_end) begin
            tx_data_o = data_off[0] ? word_r[7:0] : word_r[15:8];
        end else if (tx_idx_r == data_end) begin
            tx_data_o = tx_crc_r[7:0];
        end else begin
            tx_data_o = tx_crc_r[15:8];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    a_addr_match: assert property (accept |-> (req_addr_r == dev_addr_i) &&
        (req_addr_r != 8'h00) && (req_addr_r <= 8'hf7))
        else $error("reply to foreign or illegal address");
    a_func_echo: assert property (tx_valid_o && (tx_idx_r == 8'h01) |->
        tx_data_o == 8'h03)
        else $error("function byte not 03h");
    a_addr_echo: assert property (accept |=> tx_valid_o &&
        (tx_data_o == $past(req_addr_r)))
        else $error("reply does not open with the address");
    a_byte_count: assert property (tx_valid_o && (tx_idx_r == 8'h02) |->
        tx_data_o == 8'(req_cnt_r * 2))
        else $error("byte count wrong");
    a_fetch_order: assert property ((state_r == holding_read_pkg::ST_FETCH) |->
        rd_addr == 6'(req_start_r + 16'((tx_idx_r - 8'd3) / 2)) ##2 tx_valid_o)
        else $error("register fetched out of order");
    a_image_bound: assert property (accept |-> (req_start_r + req_cnt_r) <= 35)
        else $error("read beyond image accepted");
    a_msb_first: assert property (tx_valid_o && (tx_idx_r >= 8'd3) &&
        (tx_idx_r < data_end) && tx_idx_r[0] |-> tx_data_o == word_r[15:8])
        else $error("high byte not first");
    a_crc_low_first: assert property (tx_fire && (tx_idx_r == data_end) |->
        (tx_data_o == tx_crc_r[7:0]) ##1 (tx_data_o == $past(tx_crc_r[15:8])))
        else $error("crc byte order wrong");
    a_crc_reject: assert property (rx_last && (rx_crc_nxt != 16'h0000) |=>
        !tx_valid_o [*2])
        else $error("bad crc frame answered");
    a_reply_end: assert property (tx_fire && (tx_idx_r == data_end + 8'h01) |=>
        (state_r == holding_read_pkg::ST_IDLE))
        else $error("reply does not end after crc");

    c_accept: cover property (accept);
    c_crc_bad: cover property (rx_last && (rx_crc_nxt != 16'h0000));
    c_full_image: cover property (accept && (req_cnt_r == 16'd35) ##[1:400]
        (state_r == holding_read_pkg::ST_IDLE));
    c_stall: cover property (tx_valid_o && !tx_ready_i ##1 tx_fire);
endmodule

// ### tb/modbus_master_model.sv
// master model: frames read requests and sinks reply bytes
`timescale 1ns/1ps
module modbus_master_model (
    input wire logic clk_sys_i,
    input wire logic slow_i,
    output logic rx_gap_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic tx_ready_o
);
    logic [7:0] frame [8];
    // ----------------------------------------------------------------
    // crc and request framing
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction
    initial begin
        rx_gap_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h5a;
    end
    // a slow sink drops ready every other cycle, so a reply byte must hold
    always @(negedge clk_sys_i) begin
        tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
    end
    task automatic send_req(input logic [7:0] addr, input logic [7:0] func,
            input logic [15:0] st, input logic [15:0] n, input logic [15:0] flip);
        logic [15:0] crc;
        frame = '{addr, func, st[15:8], st[7:0],
            n[15:8], n[7:0], 8'h00, 8'h00};
        crc = 16'hffff;
        for (int i = 0; i < 6; i++) begin
            crc = crc16(crc, frame[i]);
        end
        crc = crc ^ flip;
        frame[6] = crc[7:0];
        frame[7] = crc[15:8];
        @(negedge clk_sys_i);
        rx_gap_o = 1'b1;
        @(negedge clk_sys_i);
        rx_gap_o = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rx_valid_o = 1'b1;
            rx_data_o = frame[i];
            @(negedge clk_sys_i);
        end
        rx_valid_o = 1'b0;
        // released line shows the inverse so a stale byte is never reused
        rx_data_o = ~frame[7];
    endtask
endmodule

// ### tb/holding_register_read_responder_bench.sv
// self-checking bench for the holding register read responder
`timescale 1ns/1ps
module holding_register_read_responder_bench;
    logic clk_sys_i, reset_i, rx_gap_i, rx_valid_i, tx_valid_o, tx_ready_i, img_wr_en_i, slow;
    logic [7:0] dev_addr_i, rx_data_i, tx_data_o;
    logic [5:0] img_wr_addr_i;
    logic [15:0] img_wr_data_i;
    logic [15:0] img [35];
    logic [7:0] exp_q [$];
    logic [31:0] seed;
    int fail_count, n_tests, cycles;
    // dev, addr, func, start, count, crc flip, reply expected
    localparam logic [72:0] CASES [10] = '{
        {8'h01, 8'h02, 8'h03, 16'h0000, 16'h0001, 16'h0000, 1'b0},
        {8'h00, 8'h00, 8'h03, 16'h0000, 16'h0001, 16'h0000, 1'b0},
        {8'hf8, 8'hf8, 8'h03, 16'h0000, 16'h0001, 16'h0000, 1'b0},
        {8'hf7, 8'hf7, 8'h03, 16'h0000, 16'h0002, 16'h0000, 1'b1},
        {8'h01, 8'h01, 8'h04, 16'h0000, 16'h0001, 16'h0000, 1'b0},
        {8'h01, 8'h01, 8'h03, 16'h0000, 16'h0001, 16'h0100, 1'b0},
        {8'h01, 8'h01, 8'h03, 16'h0000, 16'h0000, 16'h0000, 1'b0},
        {8'h01, 8'h01, 8'h03, 16'h0022, 16'h0002, 16'h0000, 1'b0},
        {8'h01, 8'h01, 8'h03, 16'h0000, 16'h0023, 16'h0000, 1'b1},
        {8'h01, 8'h01, 8'h03, 16'h0022, 16'h0001, 16'h0000, 1'b1}
    };
    holding_register_read_responder i_holding_register_read_responder (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .dev_addr_i(dev_addr_i),
        .rx_gap_i(rx_gap_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
        .img_wr_en_i(img_wr_en_i), .img_wr_addr_i(img_wr_addr_i),
        .img_wr_data_i(img_wr_data_i));
    modbus_master_model i_modbus_master_model (
        .clk_sys_i(clk_sys_i), .slow_i(slow), .rx_gap_o(rx_gap_i),
        .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic write_word(input logic [5:0] a);
        @(negedge clk_sys_i);
        seed = xs(seed);
        img_wr_en_i = 1'b1;
        img_wr_addr_i = a;
        img_wr_data_i = seed[15:0];
        if (a < 6'd35) img[a] = seed[15:0];
        @(negedge clk_sys_i);
        img_wr_en_i = 1'b0;
    endtask
    task automatic read_req(input logic [7:0] a, input logic [7:0] f, input logic [15:0] st,
            input logic [15:0] n, input logic [15:0] flip, input bit good);
        logic [15:0] crc;
        logic [7:0] b [$];
        if (good) begin
            b = {a, 8'h03, 8'(2 * n)};
            for (int w = st; w < st + n; w++) b = {b, img[w][15:8], img[w][7:0]};
            crc = 16'hffff;
            foreach (b[i]) crc = i_modbus_master_model.crc16(crc, b[i]);
            exp_q = {exp_q, b, crc[7:0], crc[15:8]};
        end
        i_modbus_master_model.send_req(a, f, st, n, flip);
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk_sys_i);
        repeat (6) @(posedge clk_sys_i);
        check("reply_left", 8'(exp_q.size()), 8'h00);
        @(negedge clk_sys_i);
    endtask
    // ----------------------------------------------------------------
    // reply monitor and timeout
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (reset_i === 1'b0 && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("reply_extra", 8'h01, 8'h00);
            end else begin
                check("reply_byte", tx_data_o, exp_q.pop_front());
            end
        end
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        logic [7:0] d, a, f;
        logic [15:0] st, n, fl;
        bit g;
        reset_i = 1'b1;
        dev_addr_i = 8'h01;
        img_wr_en_i = 1'b0;
        img_wr_addr_i = 6'h00;
        img_wr_data_i = 16'h0000;
        slow = 1'b0;
        seed = 32'h8b11805e;
        fail_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (8) @(negedge clk_sys_i);
        check("tx_valid_reset", {7'h00, tx_valid_o}, 8'h00);
        reset_i = 1'b0;
        for (int k = 0; k < 36; k++) write_word(6'(k));
        $display("test image_load done");
        for (int k = 0; k < 10; k++) begin
            {d, a, f, st, n, fl, g} = CASES[k];
            dev_addr_i = d;
            slow = k[0];
            read_req(a, f, st, n, fl, g);
        end
        $display("test frame_table done");
        dev_addr_i = 8'h01;
        for (int k = 0; k < 6; k++) begin
            write_word(6'(k * 5));
            seed = xs(seed);
            st = 16'(seed[15:0] % 35);
            n = 16'(1 + seed[31:16] % (35 - st));
            slow = seed[3];
            read_req(8'h01, 8'h03, st, n, 16'h0000, 1'b1);
        end
        $display("test random_subsets done");
        stop_test();
    end
endmodule
